// ===== scl_map.svh
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// Register byte offsets
`define SCL_CTRL_OFS 5'h00
`define SCL_LEN_OFS  5'h04
`define SCL_STAT_OFS 5'h08
`define SCL_DATA_OFS 5'h0c
`define SCL_CNT_OFS  5'h10
// Control fields and reset values
`define SCL_CTRL_EN  0
`define SCL_CTRL_PU  1
`define SCL_CTRL_RST 32'h0000_0003
`define SCL_LEN_RST  32'h0000_2f00
// Status fields
`define SCL_STAT_DONE 4
`define SCL_STAT_FNE  5
`define SCL_STAT_MSER 6
// Bus responses
`define SCL_RESP_OK  2'h0
`define SCL_RESP_ERR 2'h2
// Timing
`define SCL_CLK_NS   25
`define SCL_CONFIG_CLOCK_NS  1000
`define SCL_HALF     (`SCL_CONFIG_CLOCK_NS / (2 * `SCL_CLK_NS))
`endif

// ===== scl_pkg.sv
package scl_pkg;
    typedef enum logic [3:0] {
        SCL_IDLE = 4'h1,
        SCL_LOAD = 4'h2,
        SCL_FWD  = 4'h4,
        SCL_RUN  = 4'h8
    } scl_st_t;

    typedef struct packed {
        scl_st_t     st;
        logic [7:0]  div;
        logic        config_clock;
        logic [31:0] cnt;
        logic [31:0] shf;
        logic [4:0]  nb;
        logic        wv;
        logic        fwd;
        logic        dout;
        logic        drv;
        logic        hi;
        logic        lo;
        logic        run;
        logic [1:0]  din_s;
        logic [1:0]  done_s;
        logic [1:0]  pd_s;
        logic [2:0]  m_a;
        logic [2:0]  m_b;
        logic [31:0] ctrl;
        logic [31:0] len;
        logic        aw_v;
        logic [4:0]  aw_a;
        logic        w_v;
        logic [31:0] w_d;
        logic [3:0]  w_s;
        logic        b_v;
        logic [1:0]  b_r;
        logic        r_v;
        logic [31:0] r_d;
        logic [1:0]  r_r;
    } scl_state_t;
endpackage

// ===== scl_loader.sv
`timescale 1ns/10ps
`include "scl_map.svh"

// ************************************************************
// Word FIFO
// ************************************************************
module scl_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } scl_fifo_t;
    scl_fifo_t q, n;
    logic      push;
    logic      pop;
    always_comb begin
        n = q;
        in_ready_o = (q.cnt != (AW+1)'(D));
        out_valid_o = (q.cnt != '0);
        out_data_o = q.mem[q.rp];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        if (push) begin
            n.mem[q.wp] = in_data_i;
            n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            n.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            n.cnt = q.cnt - 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule
// ************************************************************
// Serial configuration loader
// ************************************************************
// How it works
// RQ1: Mode pins 000 select serial PROM loading
// RQ2: Device divides and drives PROM clock
// RQ3: PROM presents next bit per clock
// RQ4: Done line low during load, high ends
// RQ5: Indicators high and low during load
// RQ6: Master takes full own image first
// RQ7: Then forwards further bits to output
// RQ8: No function while done line low
// RQ9: Function begins when done line rises
// RQ10: Pull-up enable is software selectable
// RQ11: Other modes not loaded by master
// RQ12: Release done after own bit count
// RQ13: One bit per clock, arrival order
module scl_loader
    import scl_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    // Configuration pins
    input  wire logic        MODE_SELECT_ZERO_I,
    input  wire logic        MODE_SELECT_ONE_I,
    input  wire logic        MODE_SELECT_TWO_I,
    input  wire logic        POWER_DOWN_INPUT_I,
    input  wire logic        CFG_DATA_I,
    output logic             CONFIG_CLOCK_O,
    output logic             CFG_DATA_O,
    input  wire logic        DONE_I,
    output logic             DONE_O,
    output logic             DONE_OE_O,
    output logic             PULLUP_EN_O,
    output logic             HIGH_DURING_LOAD_O,
    output logic             LOW_DURING_LOAD_O,
    output logic             RUN_O,
    // AXI4-Lite slave
    input  wire logic [4:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    input  wire logic [4:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I
);
    localparam logic [7:0] HALF_M1 = 8'(`SCL_HALF - 1);
    scl_state_t  q, n;
    logic        f_in_rdy;
    logic        f_out_v;
    logic [31:0] f_out_d;
    logic        f_pop;
    logic        clk_run;
    logic        rise;
    logic        fall;
    logic        din;
    logic        last;
    // Captured image words, drained through the data register
    scl_fifo #(
        .W (32),
        .D (4)
    ) u_fifo (
        .clk_i       (REF_CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (q.wv),
        .in_ready_o  (f_in_rdy),
        .in_data_i   (q.shf),
        .out_valid_o (f_out_v),
        .out_ready_i (f_pop),
        .out_data_o  (f_out_d)
    );
    always_comb begin
        n = q;
        f_pop = 1'b0;
        // ****************************************************
        // Pin synchronisers
        // ****************************************************
        n.din_s = {q.din_s[0], CFG_DATA_I};
        n.done_s = {q.done_s[0], DONE_I};
        n.pd_s = {q.pd_s[0], POWER_DOWN_INPUT_I};
        n.m_a = {MODE_SELECT_TWO_I, MODE_SELECT_ONE_I,
                 MODE_SELECT_ZERO_I};
        n.m_b = q.m_a;
        din = q.din_s[1];
        // ****************************************************
        // PROM clock divider
        // ****************************************************
        if (q.wv && f_in_rdy) begin
            n.wv = 1'b0;
        end
        // Full FIFO stalls the PROM clock, so no bit is dropped
        clk_run = (q.st == SCL_LOAD || q.st == SCL_FWD) && !q.wv
                  && !q.pd_s[1];
        rise = clk_run && !q.config_clock && q.div == HALF_M1;
        fall = clk_run && q.config_clock && q.div == HALF_M1;
        // RQ2: clock generation
        if (clk_run) begin
            if (q.div == HALF_M1) begin
                n.div = '0;
                n.config_clock = !q.config_clock;
            end else begin
                n.div = q.div + 8'h01;
            end
        end
        last = (q.cnt + 32'h1 == q.len);
        // ****************************************************
        // Load sequencer
        // ****************************************************
        case (q.st)
            SCL_IDLE: begin
                // RQ1: serial mode only
                // RQ11: other modes stay idle
                if (q.ctrl[`SCL_CTRL_EN] && q.m_b == 3'h0
                    && q.len != '0) begin
                    n.st = SCL_LOAD;
                    // RQ4: hold PROM enabled
                    n.drv = 1'b1;
                    n.cnt = '0;
                    n.nb = '0;
                    n.div = '0;
                    n.config_clock = 1'b0;
                end
            end
            SCL_LOAD: begin
                // RQ3: bit valid at rising edge
                // RQ13: shift in arrival order
                if (rise) begin
                    n.shf = {q.shf[30:0], din};
                    n.nb = q.nb + 5'h01;
                    n.cnt = q.cnt + 32'h1;
                    if (q.nb == 5'h1f || last) begin
                        n.wv = 1'b1;
                        n.nb = '0;
                    end
                    // RQ6: own image complete first
                    // RQ12: release the done line
                    if (last) begin
                        n.drv = 1'b0;
                        n.st = SCL_FWD;
                    end
                end
            end
            SCL_FWD: begin
                // RQ7: pass bits downstream
                if (rise) begin
                    n.fwd = din;
                end
                if (fall) begin
                    n.dout = q.fwd;
                end
                // RQ8: wait while chain holds low
                // RQ9: start when line rises
                if (q.done_s[1]) begin
                    n.st = SCL_RUN;
                    n.dout = q.config_clock ? q.fwd : q.dout;
                    n.config_clock = 1'b0;
                    n.div = '0;
                end
            end
            SCL_RUN: begin
                n.st = SCL_RUN;
            end
            default: begin
                n.st = SCL_IDLE;
                n.drv = 1'b0;
            end
        endcase
        if (!q.ctrl[`SCL_CTRL_EN] && q.st != SCL_RUN) begin
            n.st = SCL_IDLE;
            n.drv = 1'b0;
            n.config_clock = 1'b0;
        end
        // RQ5: load indicators
        n.hi = (n.st != SCL_RUN);
        n.lo = (n.st == SCL_RUN);
        n.run = (n.st == SCL_RUN);
        // ****************************************************
        // AXI4-Lite write channel
        // ****************************************************
        AWREADY_O = !q.aw_v && !q.b_v;
        WREADY_O = !q.w_v && !q.b_v;
        if (AWVALID_I && AWREADY_O) begin
            n.aw_v = 1'b1;
            n.aw_a = AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
            n.w_v = 1'b1;
            n.w_d = WDATA_I;
            n.w_s = WSTRB_I;
        end
        if (q.aw_v && q.w_v) begin
            n.aw_v = 1'b0;
            n.w_v = 1'b0;
            n.b_v = 1'b1;
            n.b_r = `SCL_RESP_OK;
            for (int i = 0; i < 4; i++) begin
                if (q.w_s[i] && {q.aw_a[4:2], 2'h0} == `SCL_CTRL_OFS) begin
                    n.ctrl[i*8 +: 8] = q.w_d[i*8 +: 8];
                end
                if (q.w_s[i] && {q.aw_a[4:2], 2'h0} == `SCL_LEN_OFS) begin
                    n.len[i*8 +: 8] = q.w_d[i*8 +: 8];
                end
            end
            if ({q.aw_a[4:2], 2'h0} > `SCL_CNT_OFS) begin
                n.b_r = `SCL_RESP_ERR;
            end
        end
        if (q.b_v && BREADY_I) begin
            n.b_v = 1'b0;
        end
        // ****************************************************
        // AXI4-Lite read channel
        // ****************************************************
        ARREADY_O = !q.r_v;
        if (ARVALID_I && ARREADY_O) begin
            n.r_v = 1'b1;
            n.r_r = `SCL_RESP_OK;
            n.r_d = '0;
            case ({ARADDR_I[4:2], 2'h0})
                `SCL_CTRL_OFS: n.r_d = q.ctrl;
                `SCL_LEN_OFS:  n.r_d = q.len;
                `SCL_STAT_OFS: begin
                    n.r_d[3:0] = q.st;
                    n.r_d[`SCL_STAT_DONE] = q.done_s[1];
                    n.r_d[`SCL_STAT_FNE] = f_out_v;
                    n.r_d[`SCL_STAT_MSER] = (q.m_b == 3'h0);
                end
                `SCL_DATA_OFS: begin
                    // Empty FIFO reads zero and pops nothing
                    n.r_d = f_out_v ? f_out_d : '0;
                    f_pop = f_out_v;
                end
                `SCL_CNT_OFS:  n.r_d = q.cnt;
                default:       n.r_r = `SCL_RESP_ERR;
            endcase
        end
        if (q.r_v && RREADY_I) begin
            n.r_v = 1'b0;
        end
    end
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            q <= '0;
            q.st <= SCL_IDLE;
            q.hi <= 1'b1;
            q.ctrl <= `SCL_CTRL_RST;
            q.len <= `SCL_LEN_RST;
            // Synced mode pins start off serial mode: no false load
            q.m_a <= 3'h7;
            q.m_b <= 3'h7;
        end else begin
            q <= n;
        end
    end
    assign CONFIG_CLOCK_O = q.config_clock;
    assign CFG_DATA_O = q.dout;
    // RQ4: open drain, only ever pulls low
    assign DONE_O = 1'b0;
    assign DONE_OE_O = q.drv;
    // RQ10: one pull-up per chain
    assign PULLUP_EN_O = q.ctrl[`SCL_CTRL_PU];
    assign HIGH_DURING_LOAD_O = q.hi;
    assign LOW_DURING_LOAD_O = q.lo;
    assign RUN_O = q.run;
    assign BVALID_O = q.b_v;
    assign BRESP_O = q.b_r;
    assign RVALID_O = q.r_v;
    assign RDATA_O = q.r_d;
    assign RRESP_O = q.r_r;
endmodule

// ===== scl_prom_model.sv
`timescale 1ns/10ps
// ****************************************
// Serial PROM with its own address counter
// ****************************************
module scl_prom_model #(
    parameter int DEPTH = 512
) (
    // PROM pins
    input  wire logic config_clock_i,
    input  wire logic ce_n_i,
    output logic      data_o
);
    logic mem [DEPTH];
    int   addr = 0;
    always @(posedge config_clock_i)
        if (!ce_n_i)
            addr <= #5 addr + 1;
    // line high deselects
    // Deselected output flips so a stale bit never looks valid
    assign data_o = ce_n_i ? ~mem[addr] : mem[addr];
endmodule

// ===== scl_loader_monitor.sv
`timescale 1ns/10ps
`include "scl_map.svh"
// ****************************************
// Pin checker
// ****************************************
module scl_loader_monitor (
    // Observed pins
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic MODE_SELECT_ZERO_I,
    input wire logic MODE_SELECT_ONE_I,
    input wire logic MODE_SELECT_TWO_I,
    input wire logic POWER_DOWN_INPUT_I,
    input wire logic CONFIG_CLOCK_O,
    input wire logic DONE_I,
    input wire logic DONE_OE_O,
    input wire logic HIGH_DURING_LOAD_O,
    input wire logic LOW_DURING_LOAD_O,
    input wire logic RUN_O
);
    localparam logic [7:0] HALF = 8'(`SCL_HALF);
    logic       cc_q;
    logic [7:0] lvl_q;
    // Saturates so a long idle never wraps to a short phase
    always_ff @(posedge REF_CLK_I) begin
        cc_q <= CONFIG_CLOCK_O;
        if (RST_I || CONFIG_CLOCK_O != cc_q)
            lvl_q <= 8'h01;
        else if (lvl_q != 8'hff)
            lvl_q <= lvl_q + 8'h01;
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    // Entry into run may cut the high phase short
    clk_phase_a: assert property (
        CONFIG_CLOCK_O != cc_q && !RUN_O |-> lvl_q >= HALF)
        else $error("short phase");
    pd_freeze_a: assert property (
        POWER_DOWN_INPUT_I [*5] |-> $stable(CONFIG_CLOCK_O))
        else $error("clock moved in power-down");
    ind_pair_a: assert property (
        HIGH_DURING_LOAD_O == !LOW_DURING_LOAD_O
        && HIGH_DURING_LOAD_O == !RUN_O) else $error("indicators wrong");
    load_ind_a: assert property (
        DONE_OE_O |-> HIGH_DURING_LOAD_O && !RUN_O) else $error("load state");
    oe_mode_a: assert property (
        $rose(DONE_OE_O) |-> $past({MODE_SELECT_TWO_I, MODE_SELECT_ONE_I,
        MODE_SELECT_ZERO_I}) == 3'h0) else $error("load in wrong mode");
    run_held_a: assert property (
        $rose(RUN_O) |-> $past(DONE_I) && $past(DONE_I, 2))
        else $error("run while line low");
    run_prompt_a: assert property (
        $rose(DONE_I) && !DONE_OE_O && HIGH_DURING_LOAD_O |-> ##[1:6] RUN_O)
        else $error("run late");
    run_quiet_a: assert property (
        RUN_O |-> !CONFIG_CLOCK_O && !DONE_OE_O) else $error("run not quiet");
    cover property ($rose(RUN_O));
    cover property ($fell(DONE_OE_O));
    cover property (POWER_DOWN_INPUT_I [*5]);
endmodule
bind scl_loader scl_loader_monitor u_mon (
    .REF_CLK_I          (REF_CLK_I),
    .RST_I              (RST_I),
    .MODE_SELECT_ZERO_I (MODE_SELECT_ZERO_I),
    .MODE_SELECT_ONE_I  (MODE_SELECT_ONE_I),
    .MODE_SELECT_TWO_I  (MODE_SELECT_TWO_I),
    .POWER_DOWN_INPUT_I (POWER_DOWN_INPUT_I),
    .CONFIG_CLOCK_O     (CONFIG_CLOCK_O),
    .DONE_I             (DONE_I),
    .DONE_OE_O          (DONE_OE_O),
    .HIGH_DURING_LOAD_O (HIGH_DURING_LOAD_O),
    .LOW_DURING_LOAD_O  (LOW_DURING_LOAD_O),
    .RUN_O              (RUN_O)
);

// ===== scl_loader_tb.sv
`timescale 1ns/10ps
// ****************************************
// Loader bench
// ****************************************
module scl_loader_tb;
    localparam int N = 200;
    logic        clk = 1'b0, rst = 1'b1, pd = 1'b0, hold = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [2:0]  mode = 3'h7;
    logic [4:0]  awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rd, got, acc = 32'h0, q[$];
    logic        config_clock, din, dout, oe, d_o, pu, hi, lo, run, line, cc_p;
    logic        awr, wr, bv, arr, rv, bits [512];
    logic [1:0]  br, rr, resp;
    logic [7:0]  lf = 8'h3e;
    int          n_fail = 0, n_compared = 0, rises = 0, i, k;
    always #12.5 clk = ~clk;
    assign line = ~((oe & ~d_o) | hold);
    scl_prom_model u_prom (.config_clock_i(config_clock), .ce_n_i(line), .data_o(din));
    scl_loader u_dut (
        .REF_CLK_I(clk), .RST_I(rst), .MODE_SELECT_ZERO_I(mode[0]),
        .MODE_SELECT_ONE_I(mode[1]), .MODE_SELECT_TWO_I(mode[2]),
        .POWER_DOWN_INPUT_I(pd), .CFG_DATA_I(din), .CONFIG_CLOCK_O(config_clock),
        .CFG_DATA_O(dout), .DONE_I(line), .DONE_O(d_o), .DONE_OE_O(oe),
        .PULLUP_EN_O(pu), .HIGH_DURING_LOAD_O(hi), .LOW_DURING_LOAD_O(lo),
        .RUN_O(run), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr),
        .WDATA_I(wd), .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr),
        .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ara),
        .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rr),
        .RVALID_O(rv), .RREADY_I(rry));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(input string nm);
        chk(nm, 32'h1, 32'h0);
        results();
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrise(input int r, input int lim);
        for (int n = 0; n < lim && rises < r; n++)
            @(posedge clk);
        if (rises < r)
            tmo("rises");
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        int n;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awr && awv)
                awv <= 1'b0;
            if (wr && wv)
                wv <= 1'b0;
            if (bv && bry)
                break;
        end
        if (n == 50)
            tmo("bvalid");
        resp = br;
        bry <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axr(input logic [4:0] a);
        int n;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arr && arv)
                arv <= 1'b0;
            if (rv && rry)
                break;
        end
        if (n == 50)
            tmo("rvalid");
        got = rd;
        resp = rr;
        rry <= 1'b0;
        @(posedge clk);
    endtask
    // Settled values only: count PROM clock rises, check forwarded bits
    always @(negedge clk) begin
        if (config_clock && !cc_p)
            rises++;
        if (!config_clock && cc_p && rises > N)
            chk("fwd", {31'h0, bits[rises-1]}, {31'h0, dout});
        cc_p = config_clock;
    end
    initial begin
        cc_p = 1'b0;
        for (i = 0; i < 512; i++) begin
            lf = lfsr(lf);
            bits[i] = lf[0];
            u_prom.mem[i] = lf[0];
        end
        for (i = 0; i < N; i++) begin
            acc = {acc[30:0], bits[i]};
            if (i % 32 == 31 || i == N - 1) begin
                // Short last word keeps the older bits above it
                q.push_back(acc);
            end
        end
        wcyc(6);
        rst <= 1'b0;
        @(posedge clk);
        chk("pins", 32'h6, {29'h0, pu, hi, lo});
        axr(5'h00);
        chk("ctrl", 32'h3, got);
        axr(5'h04);
        chk("len", 32'h2f00, got);
        axr(5'h14);
        chk("bad_rd", 32'h2, {30'h0, resp});
        chk("bad_data", 32'h0, got);
        axw(5'h14, 32'h1);
        chk("bad_wr", 32'h2, {30'h0, resp});
        axw(5'h08, 32'hf);
        chk("ro_wr", 32'h0, {30'h0, resp});
        axw(5'h04, 32'(N));
        axr(5'h04);
        chk("len_wr", 32'(N), got);
        for (k = 1; k < 8; k++) begin
            mode <= 3'(k);
            wcyc(8);
            axr(5'h08);
            chk("mode_st", 32'h1, {25'h0, got[6:0]});
            chk("mode_oe", 32'h0, {31'h0, oe});
        end
        mode <= 3'h0;
        for (i = 0; i < 20 && oe !== 1'b1; i++)
            @(posedge clk);
        if (oe !== 1'b1)
            tmo("oe");
        axr(5'h08);
        chk("load_st", 32'h42, {25'h0, got[6:0]});
        wrise(3, 400);
        pd <= 1'b1;
        wcyc(4);
        k = rises;
        wcyc(200);
        chk("pd", 32'(k), 32'(rises));
        pd <= 1'b0;
        // Five words fit (four queued, one held), then the clock waits
        wrise(160, 20000);
        wcyc(200);
        chk("stall", 32'd160, 32'(rises));
        axr(5'h10);
        chk("count", 32'd160, got);
        for (k = 0; k < 7; k++) begin
            for (i = 0; i < 1000 && got[5] !== 1'b1; i++)
                axr(5'h08);
            if (got[5] !== 1'b1)
                tmo("fifo");
            axr(5'h0c);
            chk("word", q[k], got);
            got = 32'h0;
        end
        axr(5'h0c);
        chk("empty", 32'h0, got);
        wrise(N + 6, 2000);
        axr(5'h08);
        chk("fwd_st", 32'h4, {28'h0, got[3:0]});
        chk("fwd_pins", 32'h0, {29'h0, d_o, oe, run});
        hold <= 1'b0;
        for (i = 0; i < 10 && run !== 1'b1; i++)
            @(posedge clk);
        chk("run", 32'h1, {31'h0, run});
        k = rises;
        wcyc(100);
        chk("stop", 32'(k), 32'(rises));
        chk("run_pins", 32'h2, {29'h0, hi, lo, config_clock});
        axr(5'h08);
        chk("run_st", 32'h18, {27'h0, got[4:0]});
        axw(5'h00, 32'h1);
        wcyc(2);
        chk("pu_off", 32'h0, {31'h0, pu});
        results();
    end
endmodule
